//--- logic/atu_consts.svh
// Notes on behaviour
// - force A strobes channel A output, non-PWM only
// - force A: no flag, no clear; reads zero
// - force B strobes channel B output, non-PWM only
// - force B: no flag, no clear; reads zero
// - control B bits 5:4 read zero
// - clock select: stop, /1,/8,/32,/64,/128,/256,/1024
// - counter register is read/write
// - counter write blocks next compare match
// - compare A matched against counter each tick
// - compare B matched against counter each tick
// - external clock only when enable bit set
// - async select picks oscillator over I/O clock
// - async select change may corrupt timer registers
// - async counter write sets busy bit 4
// - async compare A write sets busy bit 3
// - async compare B write sets busy bit 2
// - async control A write sets busy bit 1
// - async control B write sets busy bit 0
// - counter and all other registers except flags read their live register values; flags offset 0xb7 is not decoded and reads zero
`ifndef ATU_CONSTS_SVH
`define ATU_CONSTS_SVH
`define ATU_ADDR_W        8
`define ATU_OFF_CTRL_A    8'hb0
`define ATU_OFF_CTRL_B    8'hb1
`define ATU_OFF_COUNT     8'hb2
`define ATU_OFF_CMP_A     8'hb3
`define ATU_OFF_CMP_B     8'hb4
`define ATU_OFF_ASYNC_STATUS_REG      8'hb6
`define ATU_OFF_FLAGS     8'hb7
`define ATU_RST_REG       8'h00
`define ATU_B_FOC_A       7
`define ATU_B_FOC_B       6
`define ATU_B_WGM2        3
`define ATU_B_EXT_CLOCK_INPUT_ENABLE       6
`define ATU_B_AS          5
`define ATU_B_CNT_UB      4
`define ATU_B_CMPA_UB     3
`define ATU_B_CMPB_UB     2
`define ATU_B_CTLA_UB     1
`define ATU_B_CTLB_UB     0
`define ATU_CTRL_B_MASK   8'h0f
`define ATU_ASYNC_STATUS_REG_WMASK    8'h60
`endif

//--- logic/atu_pkg.sv
package atu_pkg;
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic       ext_clock_input_enable;
        logic       async_sel;
        logic [4:0] busy;
        logic [4:0] pend_tog;
        logic [4:0] ack_s1;
        logic [4:0] ack_s2;
        logic [4:0] ack_s3;
        logic       cnt_tog;
        logic [1:0] match_flags;
        logic       wait_req;
        logic [7:0] rdata;
        logic       osc_s1;
        logic       osc_s2;
        logic       osc_s3;
        logic [9:0] pre;
        logic       block_match;
        logic       oc_a;
        logic       oc_b;
        logic       xtal_en;
        logic       ext_en;
    } atu_state_t;
    typedef struct packed {
        logic [7:0] address;
        logic       read;
        logic       write;
        logic [7:0] writedata;
    } atu_bus_req_t;
endpackage

//--- logic/atu_timer.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "atu_consts.svh"
module atu_timer (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire atu_pkg::atu_bus_req_t req,
    output logic [7:0]                 readdata,
    output logic                       waitrequest,
    input  wire logic                  timer_osc_input,
    output logic                       compare_a_pin,
    output logic                       compare_b_pin,
    output logic                       xtal_osc_enable,
    output logic                       ext_clock_buffer_enable,
    output logic [1:0]                 match_events
);
    atu_pkg::atu_state_t s;
    atu_pkg::atu_state_t next_s;

    function automatic logic tick_of(input logic [2:0] cs,
                                     input logic [9:0] p);
        unique case (cs)
            3'h0: tick_of = 1'b0;
            3'h1: tick_of = 1'b1;
            3'h2: tick_of = (p[2:0] == 3'h7);
            3'h3: tick_of = (p[4:0] == 5'h1f);
            3'h4: tick_of = (p[5:0] == 6'h3f);
            3'h5: tick_of = (p[6:0] == 7'h7f);
            3'h6: tick_of = (p[7:0] == 8'hff);
            3'h7: tick_of = (p == 10'h3ff);
        endcase
    endfunction

    // non-PWM: waveform modes 0 and 2 only
    function automatic logic non_pwm(input logic [7:0] ca,
                                     input logic [7:0] cb);
        non_pwm = ~ca[0] & ~cb[`ATU_B_WGM2];
    endfunction

    function automatic logic oc_next(input logic [1:0] mode,
                                     input logic       cur);
        unique case (mode)
            2'h0: oc_next = cur;
            2'h1: oc_next = ~cur;
            2'h2: oc_next = 1'b0;
            2'h3: oc_next = 1'b1;
        endcase
    endfunction

    logic       wr_hit;
    logic       rd_hit;
    logic       osc_edge;
    logic       tick;
    logic       foc_a;
    logic       foc_b;
    logic       m_a;
    logic       m_b;
    logic [4:0] wr_busy;

    always_comb begin
        next_s = s;
        // writes commit at the edge where the master sees waitrequest low
        wr_hit = req.write & ~s.wait_req;
        rd_hit = req.read & s.wait_req;
        wr_busy = 5'h00;
        // two stage waitrequest: answer lands one cycle after the request
        next_s.wait_req = ~((req.read | req.write) & s.wait_req);
        next_s.match_flags = 2'h0;
        next_s.osc_s1 = timer_osc_input;
        next_s.osc_s2 = s.osc_s1;
        next_s.osc_s3 = s.osc_s2;
        next_s.ack_s1 = s.pend_tog;
        next_s.ack_s2 = s.ack_s1;
        next_s.ack_s3 = s.ack_s2;
        // busy clears once the toggle came back through three flops
        next_s.busy = s.busy & (s.pend_tog ^ s.ack_s3);
        osc_edge = s.osc_s2 & s.osc_s3 ? 1'b0 : (s.osc_s2 & ~s.osc_s3);
        // source: rising oscillator edges when async, else every io clock
        tick = tick_of(s.ctrl_b[2:0], s.pre);
        if (s.async_sel ? osc_edge : 1'b1) begin
            next_s.pre = s.pre + 10'h001;
        end
        if (s.async_sel & ~osc_edge) begin
            tick = 1'b0;
        end
        foc_a = 1'b0;
        foc_b = 1'b0;
        m_a = tick & ~s.block_match & (s.count == s.cmp_a);
        m_b = tick & ~s.block_match & (s.count == s.cmp_b);
        if (tick) begin
            next_s.block_match = 1'b0;
            if (s.ctrl_a[1:0] == 2'h2 && m_a) begin
                next_s.count = 8'h00;
            end else begin
                next_s.count = s.count + 8'h01;
            end
        end
        if (wr_hit) begin
            unique case (req.address)
                `ATU_OFF_CTRL_A: begin
                    next_s.ctrl_a = req.writedata;
                    wr_busy[`ATU_B_CTLA_UB] = 1'b1;
                end
                `ATU_OFF_CTRL_B: begin
                    next_s.ctrl_b = req.writedata & `ATU_CTRL_B_MASK;
                    wr_busy[`ATU_B_CTLB_UB] = 1'b1;
                    foc_a = req.writedata[`ATU_B_FOC_A];
                    foc_b = req.writedata[`ATU_B_FOC_B];
                end
                `ATU_OFF_COUNT: begin
                    next_s.count = req.writedata;
                    next_s.block_match = 1'b1;
                    wr_busy[`ATU_B_CNT_UB] = 1'b1;
                end
                `ATU_OFF_CMP_A: begin
                    next_s.cmp_a = req.writedata;
                    wr_busy[`ATU_B_CMPA_UB] = 1'b1;
                end
                `ATU_OFF_CMP_B: begin
                    next_s.cmp_b = req.writedata;
                    wr_busy[`ATU_B_CMPB_UB] = 1'b1;
                end
                `ATU_OFF_ASYNC_STATUS_REG: begin
                    next_s.ext_clock_input_enable = req.writedata[`ATU_B_EXT_CLOCK_INPUT_ENABLE];
                    next_s.async_sel = req.writedata[`ATU_B_AS];
                    // switching source leaves counter state undefined
                end
                default: begin
                end
            endcase
        end
        if (s.async_sel) begin
            // async writes land in the register at once and raise their busy bit
            next_s.busy = next_s.busy | wr_busy;
            next_s.pend_tog = s.pend_tog ^ wr_busy;
        end
        // forced match only in non-PWM modes
        if (!non_pwm(s.ctrl_a, s.ctrl_b)) begin
            foc_a = 1'b0;
            foc_b = 1'b0;
        end
        if (m_a | foc_a) begin
            next_s.oc_a = oc_next(s.ctrl_a[7:6], s.oc_a);
        end
        if (m_b | foc_b) begin
            next_s.oc_b = oc_next(s.ctrl_a[5:4], s.oc_b);
        end
        // forced matches raise no event and do not clear
        next_s.match_flags = {m_b, m_a};
        // crystal runs only while external input disabled
        next_s.xtal_en = next_s.async_sel & ~next_s.ext_clock_input_enable;
        next_s.ext_en = next_s.async_sel & next_s.ext_clock_input_enable;
        if (rd_hit) begin
            unique case (req.address)
                `ATU_OFF_CTRL_A: next_s.rdata = s.ctrl_a;
                `ATU_OFF_CTRL_B: next_s.rdata = s.ctrl_b;
                `ATU_OFF_COUNT:  next_s.rdata = s.count;
                `ATU_OFF_CMP_A:  next_s.rdata = s.cmp_a;
                `ATU_OFF_CMP_B:  next_s.rdata = s.cmp_b;
                `ATU_OFF_ASYNC_STATUS_REG:   next_s.rdata = {1'b0, s.ext_clock_input_enable,
                                                 s.async_sel, s.busy};
                default:         next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.wait_req <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign readdata = s.rdata;
    assign waitrequest = s.wait_req;
    assign compare_a_pin = s.oc_a;
    assign compare_b_pin = s.oc_b;
    assign xtal_osc_enable = s.xtal_en;
    assign ext_clock_buffer_enable = s.ext_en;
    assign match_events = s.match_flags;

    property p_ctrl_b_reserved;
        @(posedge clk) disable iff (rst)
        s.ctrl_b[7:4] == 4'h0;
    endproperty
    a_ctrl_b_reserved: assert property (p_ctrl_b_reserved)
        else $error("control b upper bits not zero");

    property p_block_after_write;
        @(posedge clk) disable iff (rst)
        (wr_hit && req.address == `ATU_OFF_COUNT) |=> !m_a && !m_b;
    endproperty
    a_block_after_write: assert property (p_block_after_write)
        else $error("match seen right after counter write");

    property p_busy_count;
        @(posedge clk) disable iff (rst)
        (wr_hit && s.async_sel && req.address == `ATU_OFF_COUNT)
            |=> s.busy[`ATU_B_CNT_UB];
    endproperty
    a_busy_count: assert property (p_busy_count)
        else $error("counter busy not set");

    property p_busy_release;
        @(posedge clk) disable iff (rst)
        $rose(s.busy[`ATU_B_CMPA_UB]) |-> ##[3:5] !s.busy[`ATU_B_CMPA_UB];
    endproperty
    a_busy_release: assert property (p_busy_release)
        else $error("compare a busy did not clear in time");

    property p_sync_busy_b;
        @(posedge clk) disable iff (rst)
        (wr_hit && s.async_sel && req.address == `ATU_OFF_CMP_B)
            |=> s.busy[`ATU_B_CMPB_UB] [*2];
    endproperty
    a_sync_busy_b: assert property (p_sync_busy_b)
        else $error("compare b busy dropped early");

    property p_no_busy_sync;
        @(posedge clk) disable iff (rst)
        (!s.async_sel && s.busy == 5'h00 && wr_hit) |=> s.busy == 5'h00;
    endproperty
    a_no_busy_sync: assert property (p_no_busy_sync)
        else $error("busy set in synchronous mode");

    property p_xtal;
        @(posedge clk) disable iff (rst)
        s.xtal_en |-> !s.ext_clock_input_enable;
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal on with external clock");

    property p_force_quiet;
        @(posedge clk) disable iff (rst)
        (foc_a && !m_a) |=> !s.match_flags[0];
    endproperty
    a_force_quiet: assert property (p_force_quiet)
        else $error("forced compare a raised event");

    property p_force_a;
        @(posedge clk) disable iff (rst)
        (foc_a && !m_a && s.ctrl_a[7:6] == 2'h1) |=> s.oc_a != $past(s.oc_a);
    endproperty
    a_force_a: assert property (p_force_a)
        else $error("forced compare a did not toggle");

    property p_force_b;
        @(posedge clk) disable iff (rst)
        (foc_b && !m_b && s.ctrl_a[5:4] == 2'h3) |=> s.oc_b;
    endproperty
    a_force_b: assert property (p_force_b)
        else $error("forced compare b did not set");

    property p_force_b_quiet;
        @(posedge clk) disable iff (rst)
        (foc_b && !m_b) |=> !s.match_flags[1];
    endproperty
    a_force_b_quiet: assert property (p_force_b_quiet)
        else $error("forced compare b raised event");

    property p_force_no_clear;
        @(posedge clk) disable iff (rst)
        (foc_a && !m_a && tick) |=> s.count == $past(s.count) + 8'h01;
    endproperty
    a_force_no_clear: assert property (p_force_no_clear)
        else $error("forced compare a cleared the counter");

    property p_pwm_no_force_a;
        @(posedge clk) disable iff (rst)
        (wr_hit && req.address == `ATU_OFF_CTRL_B && req.writedata[7]
            && s.ctrl_a[0] && !m_a) |=> s.oc_a == $past(s.oc_a);
    endproperty
    a_pwm_no_force_a: assert property (p_pwm_no_force_a)
        else $error("force a acted in pwm mode");

    property p_pwm_no_force_b;
        @(posedge clk) disable iff (rst)
        (wr_hit && req.address == `ATU_OFF_CTRL_B && req.writedata[6]
            && s.ctrl_a[0] && !m_b) |=> s.oc_b == $past(s.oc_b);
    endproperty
    a_pwm_no_force_b: assert property (p_pwm_no_force_b)
        else $error("force b acted in pwm mode");

    property p_match_clear;
        @(posedge clk) disable iff (rst)
        (m_a && s.ctrl_a[1:0] == 2'h2 && !wr_hit) |=> s.count == 8'h00;
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("compare a match did not clear counter");

    property p_event_a;
        @(posedge clk) disable iff (rst)
        m_a |=> s.match_flags[0];
    endproperty
    a_event_a: assert property (p_event_a)
        else $error("compare a match gave no event");

    property p_event_b;
        @(posedge clk) disable iff (rst)
        m_b |=> s.match_flags[1];
    endproperty
    a_event_b: assert property (p_event_b)
        else $error("compare b match gave no event");

    property p_stopped;
        @(posedge clk) disable iff (rst)
        (s.ctrl_b[2:0] == 3'h0 && !wr_hit) |=> s.count == $past(s.count);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved while stopped");

    property p_div8;
        @(posedge clk) disable iff (rst)
        (s.ctrl_b[2:0] == 3'h2 && s.pre[2:0] != 3'h7) |-> !tick;
    endproperty
    a_div8: assert property (p_div8)
        else $error("divide by 8 ticked early");

    property p_count_write;
        @(posedge clk) disable iff (rst)
        (wr_hit && req.address == `ATU_OFF_COUNT)
            |=> s.count == $past(req.writedata);
    endproperty
    a_count_write: assert property (p_count_write)
        else $error("counter write not stored");

    property p_busy_cmp_a;
        @(posedge clk) disable iff (rst)
        (wr_hit && s.async_sel && req.address == `ATU_OFF_CMP_A)
            |=> s.busy[`ATU_B_CMPA_UB];
    endproperty
    a_busy_cmp_a: assert property (p_busy_cmp_a)
        else $error("compare a busy not set");

    property p_busy_ctl_a;
        @(posedge clk) disable iff (rst)
        (wr_hit && s.async_sel && req.address == `ATU_OFF_CTRL_A)
            |=> s.busy[`ATU_B_CTLA_UB];
    endproperty
    a_busy_ctl_a: assert property (p_busy_ctl_a)
        else $error("control a busy not set");

    property p_busy_ctl_b;
        @(posedge clk) disable iff (rst)
        (wr_hit && s.async_sel && req.address == `ATU_OFF_CTRL_B)
            |=> s.busy[`ATU_B_CTLB_UB];
    endproperty
    a_busy_ctl_b: assert property (p_busy_ctl_b)
        else $error("control b busy not set");

    property p_ext;
        @(posedge clk) disable iff (rst)
        s.ext_en |-> s.ext_clock_input_enable && s.async_sel;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external buffer on without async and enable");

    property p_sync_off;
        @(posedge clk) disable iff (rst)
        !s.async_sel |-> !s.xtal_en && !s.ext_en;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("oscillator enabled in synchronous mode");

    property p_async_tick;
        @(posedge clk) disable iff (rst)
        (s.async_sel && !osc_edge) |-> !tick;
    endproperty
    a_async_tick: assert property (p_async_tick)
        else $error("tick without oscillator edge");

    property p_read_ctrl_b;
        @(posedge clk) disable iff (rst)
        (rd_hit && req.address == `ATU_OFF_CTRL_B) |=> s.rdata[7:4] == 4'h0;
    endproperty
    a_read_ctrl_b: assert property (p_read_ctrl_b)
        else $error("control b read upper bits not zero");

    property p_read_count;
        @(posedge clk) disable iff (rst)
        (rd_hit && req.address == `ATU_OFF_COUNT)
            |=> s.rdata == $past(s.count);
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("counter read not live value");

    property p_read_cmp_a;
        @(posedge clk) disable iff (rst)
        (rd_hit && req.address == `ATU_OFF_CMP_A)
            |=> s.rdata == $past(s.cmp_a);
    endproperty
    a_read_cmp_a: assert property (p_read_cmp_a)
        else $error("compare a read not stored value");
endmodule

//--- testbench/async_timer2_control_update_tb.sv
`timescale 1ns/1ps
module async_timer2_control_update_tb;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    atu_pkg::atu_bus_req_t bus_req = '0;
    logic                  osc = 1'b0;
    logic [7:0]            readdata;
    logic                  waitrequest;
    logic                  pin_a;
    logic                  pin_b;
    logic                  xtal_en;
    logic                  ext_en;
    logic [1:0]            match_ev;
    logic [7:0]            rd;
    int                    failures = 0;
    int                    cmp_count = 0;
    int                    cyc = 0;

    atu_timer atu_timer_inst (
        .clk                     (clk),
        .rst                     (rst),
        .req                     (bus_req),
        .readdata                (readdata),
        .waitrequest             (waitrequest),
        .timer_osc_input         (osc),
        .compare_a_pin           (pin_a),
        .compare_b_pin           (pin_b),
        .xtal_osc_enable         (xtal_en),
        .ext_clock_buffer_enable (ext_en),
        .match_events            (match_ev)
    );

    always #25 clk = ~clk;

    // oscillator stand-in, far below the bus clock so the syncs can see it
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 8 == 7) begin
            osc <= ~osc;
        end
        if (cyc == 40000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic in_range(string name, int lo, int hi, logic [7:0] got);
        cmp_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            failures++;
            $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi,
                     got);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        bus_req.address <= a;
        bus_req.writedata <= d;
        bus_req.write <= wr;
        bus_req.read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        check("bus answer", 8'h00, (n < 50) ? 8'h00 : 8'hff);
        bus_req.write <= 1'b0;
        bus_req.read <= 1'b0;
    endtask

    task automatic rd_chk(string name, logic [7:0] a, logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(name, exp, rd);
    endtask

    task automatic wait_ev(int idx);
        int n;
        n = 0;
        while (match_ev[idx] !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check("match event", 8'h01, {7'h00, match_ev[idx]});
    endtask

    task automatic t_fields();
        rd_chk("status reset", 8'hb6, 8'h00);
        bus(1'b1, 8'hb1, 8'h37);
        rd_chk("control b reserved", 8'hb1, 8'h07);
        bus(1'b1, 8'hb1, 8'hc0);
        rd_chk("force bits", 8'hb1, 8'h00);
    endtask

    task automatic t_force();
        bus(1'b1, 8'hb0, 8'h51);
        bus(1'b1, 8'hb1, 8'h00);
        repeat (3) @(posedge clk);
        check("pin a in pwm", 8'h00, {7'h00, pin_a});
        bus(1'b1, 8'hb0, 8'h50);
        bus(1'b1, 8'hb1, 8'h80);
        repeat (3) @(posedge clk);
        check("pin a forced", 8'h01, {7'h00, pin_a});
        bus(1'b1, 8'hb1, 8'h40);
        repeat (3) @(posedge clk);
        check("pin b forced", 8'h01, {7'h00, pin_b});
        check("no event", 8'h00, {6'h00, match_ev});
        bus(1'b1, 8'hb1, 8'hc0);
        repeat (3) @(posedge clk);
        check("both toggled", 8'h00, {6'h00, pin_b, pin_a});
    endtask

    task automatic t_regs();
        bus(1'b1, 8'hb2, 8'ha5);
        rd_chk("counter", 8'hb2, 8'ha5);
        bus(1'b1, 8'hb3, 8'h3c);
        rd_chk("compare a", 8'hb3, 8'h3c);
        bus(1'b1, 8'hb4, 8'hc3);
        rd_chk("compare b", 8'hb4, 8'hc3);
        rd_chk("unmapped", 8'hb5, 8'h00);
    endtask

    task automatic t_match();
        int n;
        bus(1'b1, 8'hb2, 8'h00);
        bus(1'b1, 8'hb3, 8'h10);
        bus(1'b1, 8'hb4, 8'h20);
        bus(1'b1, 8'hb1, 8'h01);
        wait_ev(0);
        wait_ev(1);
        bus(1'b1, 8'hb2, 8'h10);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            n += match_ev[0];
        end
        check("blocked match", 8'h00, n[7:0]);
        bus(1'b1, 8'hb1, 8'h00);
    endtask

    task automatic t_prescale();
        int div [6] = '{8, 32, 64, 128, 256, 1024};
        for (int c = 2; c < 8; c++) begin
            bus(1'b1, 8'hb2, 8'h00);
            bus(1'b1, 8'hb1, c[7:0]);
            repeat (div[c - 2] * 6) @(posedge clk);
            bus(1'b1, 8'hb1, 8'h00);
            bus(1'b0, 8'hb2, 8'h00);
            in_range("divided count", 5, 7, rd);
        end
    endtask

    task automatic t_async();
        logic [7:0] offs [5] = '{8'hb2, 8'hb3, 8'hb4, 8'hb0, 8'hb1};
        logic [7:0] exp_b;
        bus(1'b1, 8'hb6, 8'h40);
        bus(1'b1, 8'hb6, 8'h60);
        repeat (3) @(posedge clk);
        check("ext clock", 8'h01, {6'h00, xtal_en, ext_en});
        bus(1'b1, 8'hb6, 8'h20);
        repeat (3) @(posedge clk);
        check("crystal", 8'h02, {6'h00, xtal_en, ext_en});
        for (int i = 0; i < 5; i++) begin
            repeat (200) @(posedge clk);
            bus(1'b1, offs[i], 8'h00);
            exp_b = 8'h20 | (8'h10 >> i);
            rd_chk("busy set", 8'hb6, exp_b);
            repeat (200) @(posedge clk);
            rd_chk("busy clear", 8'hb6, 8'h20);
        end
        bus(1'b1, 8'hb1, 8'h01);
        repeat (160) @(posedge clk);
        bus(1'b1, 8'hb1, 8'h00);
        repeat (200) @(posedge clk);
        bus(1'b0, 8'hb2, 8'h00);
        in_range("osc count", 8, 12, rd);
        bus(1'b1, 8'hb6, 8'h00);
        bus(1'b1, 8'hb2, 8'h55);
        rd_chk("no busy in sync", 8'hb6, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_fields();
        t_force();
        t_regs();
        t_match();
        t_prescale();
        t_async();
        stop_test();
    end
endmodule
